// File: inc/sbm_cfg.svh
`ifndef SBM_CFG_SVH
`define SBM_CFG_SVH

// Register byte offsets
`define SBM_OFS_CTRL       8'h00
`define SBM_OFS_TXDATA     8'h04
`define SBM_OFS_STATUS     8'h08
`define SBM_OFS_RXDATA     8'h0C
`define SBM_OFS_RATE       8'h10

// Control register fields
`define SBM_CTL_PORT_EN    0
`define SBM_CTL_CLOCKED    1
`define SBM_CTL_MASTER     2
`define SBM_CTL_TX_EN      3
`define SBM_CTL_BREAK      4
`define SBM_CTL_NINE       5
`define SBM_CTL_NINTH      6
`define SBM_CTL_SINGLE_RX  7
`define SBM_CTL_CONT_RX    8
`define SBM_CTL_CPOL       9
`define SBM_CTL_DPOL       10
`define SBM_CTL_WAKE       11
`define SBM_CTL_W          12

// Status register fields
`define SBM_ST_SR_EMPTY    0
`define SBM_ST_TB_EMPTY    1
`define SBM_ST_RX_FLAG     2
`define SBM_ST_FRAME_ERR   3
`define SBM_ST_RX_IDLE     4

// Reset values
`define SBM_CTRL_RST       12'h000
`define SBM_RATE_RST       16'h0067

// Bit counts per character
`define SBM_BREAK_ZEROS    4'hC
`define SBM_BITS_8         4'h8
`define SBM_BITS_9         4'h9

`endif

// File: inc/sbm_pkg.sv
package sbm_pkg;

    typedef enum logic [2:0]
    {
        TX_IDLE  = 3'b000,
        TX_START = 3'b001,
        TX_DATA  = 3'b010,
        TX_STOP  = 3'b011,
        TX_SYNC  = 3'b100
    } sbm_tx_state_t;

    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } sbm_rx_state_t;

endpackage

// File: src/sbm_serial_port.sv
// Summary of operation
// - Break is start, twelve zeros, stop
// - Break request plus enable: write sends break
// - Break request self-clears after stop bit
// - Shifter-empty status also covers break
// - Buffer-empty flag when holding register empties
// - Break received: flag, framing error, zero
// - Wake mode flags edge, then receives
// - Wake clear needs no instruction clocks
// - Receiver idle while wake mode set
// - Synchronous: one data, one clock, half-duplex
// - Master mode bits; receive enables select direction
// - Master drives and enables clock pin
// - One clock per bit, leading-edge data
// - Clock polarity selects idle level, edges
// - Master transmit drives data and clock
// - Holding register waits for shifter empty
// - Data polarity resets high-true, inverts both
// - Shift register hidden from software
// - Wake clears on rising receive edge
`timescale 1ns/1ps
`include "sbm_cfg.svh"

module sbm_serial_port
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        DATA_I,
    output logic             DATA_O,
    output logic             DATA_OE_N,
    output logic             CK_O,
    output logic             CK_OE_N
);

    logic [11:0]           ctrl;
    logic [15:0]           rate;
    logic [15:0]           rate_cnt;
    logic                  tick;
    logic                  half;
    logic                  setup_ph;
    logic                  acc_wr;
    logic                  acc_rd;
    logic                  mapped;
    logic                  port_en;
    logic                  sync_mode;
    logic                  sync_master;
    logic                  tx_ok;
    logic                  hold_full;
    logic [8:0]            hold_data;
    logic                  hold_brk;
    logic [8:0]            shifter;
    logic                  cur_brk;
    logic [3:0]            bits_left;
    logic                  tx_line;
    logic                  sclk;
    logic                  end_char;
    logic                  load_now;
    logic                  brk_done;
    sbm_pkg::sbm_tx_state_t tx_state;
    logic                  rx_m;
    logic                  rx_s;
    logic                  rx_in;
    logic                  rx_prev;
    logic                  rx_fall;
    logic                  rx_rise;
    sbm_pkg::sbm_rx_state_t rx_state;
    logic [15:0]           rx_cnt;
    logic [2:0]            rx_bits;
    logic [7:0]            rx_shift;
    logic [7:0]            rx_data;
    logic                  rx_flag;
    logic                  frame_err;
    logic                  rx_done;
    logic                  wake_seen;
    logic                  wake_edge;
    logic                  wake_clr;

    // Register offset match, used by both read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Bus phase decode
    assign setup_ph = PSEL & ~PENABLE;
    assign acc_wr   = PSEL & PENABLE & PWRITE;
    assign acc_rd   = PSEL & PENABLE & ~PWRITE;
    assign mapped   = hit(PADDR, `SBM_OFS_CTRL) | hit(PADDR, `SBM_OFS_TXDATA)
                    | hit(PADDR, `SBM_OFS_STATUS) | hit(PADDR, `SBM_OFS_RXDATA)
                    | hit(PADDR, `SBM_OFS_RATE);
    assign PREADY   = 1'b1;
    assign PSLVERR  = PSEL & PENABLE & ~mapped;

    // Mode decode
    assign port_en     = ctrl[`SBM_CTL_PORT_EN];
    assign sync_mode   = port_en & ctrl[`SBM_CTL_CLOCKED];
    assign sync_master = sync_mode & ctrl[`SBM_CTL_MASTER];
    // asynchronous transmit needs only the enables; clocked transmit only as master with both receive enables clear
    assign tx_ok = port_en & ctrl[`SBM_CTL_TX_EN]
                 & (~ctrl[`SBM_CTL_CLOCKED]
                    | (sync_master & ~ctrl[`SBM_CTL_SINGLE_RX] & ~ctrl[`SBM_CTL_CONT_RX]));

    // Control register; software write beats hardware clear
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            ctrl <= `SBM_CTRL_RST;
        else if (acc_wr && hit(PADDR, `SBM_OFS_CTRL))
            ctrl <= PWDATA[`SBM_CTL_W-1:0];
        else
        begin
            // break request cleared after its stop bit
            if (brk_done)
                ctrl[`SBM_CTL_BREAK] <= 1'b0;
            // wake mode ends on rising edge
            if (wake_clr)
                ctrl[`SBM_CTL_WAKE] <= 1'b0;
        end
    end

    // Rate divisor register
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            rate <= `SBM_RATE_RST;
        else if (acc_wr && hit(PADDR, `SBM_OFS_RATE))
            rate <= PWDATA[15:0];
    end

    // Read data captured in the setup phase
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            PRDATA <= 32'h0000_0000;
        else if (setup_ph)
        begin
            PRDATA <= 32'h0000_0000;
            if (hit(PADDR, `SBM_OFS_CTRL))
                PRDATA[`SBM_CTL_W-1:0] <= ctrl;
            else if (hit(PADDR, `SBM_OFS_STATUS))
            begin
                PRDATA[`SBM_ST_SR_EMPTY]  <= (tx_state == sbm_pkg::TX_IDLE);
                PRDATA[`SBM_ST_TB_EMPTY]  <= ~hold_full;
                PRDATA[`SBM_ST_RX_FLAG]   <= rx_flag;
                PRDATA[`SBM_ST_FRAME_ERR] <= frame_err;
                PRDATA[`SBM_ST_RX_IDLE]   <= (rx_state == sbm_pkg::RX_IDLE);
            end
            else if (hit(PADDR, `SBM_OFS_RXDATA))
                PRDATA[7:0] <= rx_data;
            else if (hit(PADDR, `SBM_OFS_RATE))
                PRDATA[15:0] <= rate;
        end
    end

    // one rate period per bit; half marks trailing edge
    assign tick = (rate_cnt == 16'h0000);
    assign half = (rate_cnt == (rate >> 1)) & ~tick;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            rate_cnt <= 16'h0000;
        else if (tick)
            rate_cnt <= rate;
        else
            rate_cnt <= rate_cnt - 16'h0001;
    end

    // one holding slot beside the shifter
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            hold_full <= 1'b0;
            hold_data <= 9'h000;
            hold_brk  <= 1'b0;
        end
        else if (!tx_ok)
            hold_full <= 1'b0;
        else if (load_now)
            hold_full <= 1'b0;
        else if (acc_wr && hit(PADDR, `SBM_OFS_TXDATA) && !hold_full)
        begin
            hold_full <= 1'b1;
            hold_data <= {ctrl[`SBM_CTL_NINTH], PWDATA[7:0]};
            // break marked at write; a byte queued behind one stays data
            hold_brk  <= ctrl[`SBM_CTL_BREAK] & ctrl[`SBM_CTL_TX_EN] & ~cur_brk;
        end
    end

    // End of the character being shifted
    assign end_char = tick & (((tx_state == sbm_pkg::TX_STOP))
                    | ((tx_state == sbm_pkg::TX_SYNC) && (bits_left == 4'h0)));
    // move to shifter once it is empty
    assign load_now = tx_ok & hold_full & tick
                    & ((tx_state == sbm_pkg::TX_IDLE) | end_char);
    assign brk_done = end_char & cur_brk & (tx_state == sbm_pkg::TX_STOP);

    // Transmit sequencer
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            tx_state  <= sbm_pkg::TX_IDLE;
            shifter   <= 9'h000;
            cur_brk   <= 1'b0;
            bits_left <= 4'h0;
            tx_line   <= 1'b1;
        end
        else if (!tx_ok)
        begin
            tx_state <= sbm_pkg::TX_IDLE;
            tx_line  <= 1'b1;
            cur_brk  <= 1'b0;
        end
        else if (load_now)
        begin
            // break sends zeros, written value dropped, except that a clocked character still sends written bit 0 first
            shifter <= hold_brk ? 9'h000 : hold_data;
            cur_brk <= hold_brk & ~sync_mode;
            if (sync_mode)
            begin
                // first bit on first leading edge
                tx_line   <= hold_data[0];
                bits_left <= ctrl[`SBM_CTL_NINE] ? `SBM_BITS_9 - 4'h1 : `SBM_BITS_8 - 4'h1;
                tx_state  <= sbm_pkg::TX_SYNC;
            end
            else
            begin
                tx_line  <= 1'b0;
                tx_state <= sbm_pkg::TX_START;
            end
        end
        else if (tick)
        begin
            case (tx_state)
                sbm_pkg::TX_START:
                begin
                    tx_line  <= shifter[0];
                    if (cur_brk)
                        bits_left <= `SBM_BREAK_ZEROS;
                    else if (ctrl[`SBM_CTL_NINE])
                        bits_left <= `SBM_BITS_9;
                    else
                        bits_left <= `SBM_BITS_8;
                    tx_state <= sbm_pkg::TX_DATA;
                end
                sbm_pkg::TX_DATA:
                begin
                    if (bits_left == 4'h1)
                    begin
                        tx_line  <= 1'b1;
                        tx_state <= sbm_pkg::TX_STOP;
                    end
                    else
                    begin
                        tx_line   <= shifter[1];
                        shifter   <= {1'b0, shifter[8:1]};
                        bits_left <= bits_left - 4'h1;
                    end
                end
                sbm_pkg::TX_STOP:
                begin
                    cur_brk  <= 1'b0;
                    tx_state <= sbm_pkg::TX_IDLE;
                end
                sbm_pkg::TX_SYNC:
                begin
                    // no clock beyond the last bit
                    if (bits_left == 4'h0)
                        tx_state <= sbm_pkg::TX_IDLE;
                    else
                    begin
                        tx_line   <= shifter[1];
                        shifter   <= {1'b0, shifter[8:1]};
                        bits_left <= bits_left - 4'h1;
                    end
                end
                default:
                    tx_state <= sbm_pkg::TX_IDLE;
            endcase
        end
    end

    // shift clock: leading edge at tick, trailing at half
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            sclk <= 1'b0;
        else if (tick && ((load_now && sync_mode)
                 || (tx_state == sbm_pkg::TX_SYNC && bits_left != 4'h0)))
            sclk <= ~ctrl[`SBM_CTL_CPOL];
        else if (half || tx_state != sbm_pkg::TX_SYNC)
            sclk <= ctrl[`SBM_CTL_CPOL];
    end

    // Pin drivers
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            DATA_O    <= 1'b0;
            DATA_OE_N <= 1'b1;
            CK_O      <= 1'b1;
            CK_OE_N   <= 1'b1;
        end
        else
        begin
            DATA_O    <= tx_line ^ ctrl[`SBM_CTL_DPOL];
            // data pin driven in master transmit
            DATA_OE_N <= ~(tx_ok & sync_master);
            // clock pin enabled in master mode
            // idle level outside a character, no stray edge
            CK_O      <= sync_master
                         ? ((tx_state == sbm_pkg::TX_SYNC) ? sclk : ctrl[`SBM_CTL_CPOL])
                         : (tx_line ^ ctrl[`SBM_CTL_DPOL]);
            CK_OE_N   <= ~(sync_master | (tx_ok & ~sync_mode));
        end
    end

    // Receive line through two flops
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rx_m    <= 1'b1;
            rx_s    <= 1'b1;
            rx_prev <= 1'b1;
        end
        else
        begin
            rx_m    <= DATA_I;
            rx_s    <= rx_m;
            rx_prev <= rx_in;
        end
    end

    assign rx_in   = rx_s ^ ctrl[`SBM_CTL_DPOL];
    assign rx_fall = rx_prev & ~rx_in;
    assign rx_rise = ~rx_prev & rx_in;

    // wake mode watches fall then rise
    assign wake_edge = port_en & ~ctrl[`SBM_CTL_CLOCKED] & ctrl[`SBM_CTL_WAKE]
                     & rx_fall & ~wake_seen;
    // clear taken from line edge alone
    assign wake_clr  = port_en & ctrl[`SBM_CTL_WAKE] & wake_seen & rx_rise;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            wake_seen <= 1'b0;
        else if (!ctrl[`SBM_CTL_WAKE] || wake_clr)
            wake_seen <= 1'b0;
        else if (wake_edge)
            wake_seen <= 1'b1;
    end

    // Asynchronous receiver
    always_ff @(posedge CLK)
    begin
        rx_done <= 1'b0;
        if (!RST_N)
        begin
            rx_state <= sbm_pkg::RX_IDLE;
            rx_cnt   <= 16'h0000;
            rx_bits  <= 3'h0;
            rx_shift <= 8'h00;
            rx_done  <= 1'b0;
        end
        // receiver held idle in wake mode
        else if (!port_en || ctrl[`SBM_CTL_CLOCKED] || ctrl[`SBM_CTL_WAKE])
            rx_state <= sbm_pkg::RX_IDLE;
        else if (rx_state == sbm_pkg::RX_IDLE)
        begin
            if (rx_fall)
            begin
                rx_cnt   <= rate >> 1;
                rx_state <= sbm_pkg::RX_START;
            end
        end
        else if (rx_cnt != 16'h0000)
            rx_cnt <= rx_cnt - 16'h0001;
        else
        begin
            rx_cnt <= rate;
            case (rx_state)
                sbm_pkg::RX_START:
                begin
                    rx_bits  <= 3'h0;
                    rx_state <= rx_in ? sbm_pkg::RX_IDLE : sbm_pkg::RX_DATA;
                end
                sbm_pkg::RX_DATA:
                begin
                    rx_shift <= {rx_in, rx_shift[7:1]};
                    rx_bits  <= rx_bits + 3'h1;
                    if (rx_bits == 3'h7)
                        rx_state <= sbm_pkg::RX_STOP;
                end
                sbm_pkg::RX_STOP:
                begin
                    rx_done  <= 1'b1;
                    rx_state <= sbm_pkg::RX_IDLE;
                end
                default:
                    rx_state <= sbm_pkg::RX_IDLE;
            endcase
        end
    end

    // break shows as zero byte with framing error
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rx_data   <= 8'h00;
            frame_err <= 1'b0;
        end
        else if (rx_done)
        begin
            rx_data   <= rx_shift;
            frame_err <= ~rx_in;
        end
    end

    // Receive flag: set wins over the clear by a data read
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            rx_flag <= 1'b0;
        else if (rx_done || wake_edge)
            rx_flag <= 1'b1;
        else if (acc_rd && hit(PADDR, `SBM_OFS_RXDATA))
            rx_flag <= 1'b0;
    end

endmodule

// File: dv/sbm_serial_port_props.sv
`timescale 1ns/1ps
`include "sbm_cfg.svh"

module sbm_serial_port_props
(
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        DATA_I,
    input wire logic        DATA_O,
    input wire logic        DATA_OE_N,
    input wire logic        CK_O,
    input wire logic        CK_OE_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    logic acc;
    logic mapped;

    // Access phase and decoded register window
    assign acc    = PSEL && PENABLE;
    assign mapped = PADDR inside {`SBM_OFS_CTRL, `SBM_OFS_TXDATA, `SBM_OFS_STATUS,
                                  `SBM_OFS_RXDATA, `SBM_OFS_RATE};

    // Zero wait state answer
    a_ready_in_access: assert property (acc |-> PREADY)
        else $error("ready missing in access phase");
    a_err_unmapped: assert property (acc && !mapped |-> PSLVERR)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (acc && mapped |-> !PSLVERR)
        else $error("error on mapped access");
    a_rd_unmapped_zero: assert property (acc && !PWRITE && !mapped |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_txdata_reads_zero: assert property (
        acc && !PWRITE && PADDR == `SBM_OFS_TXDATA |-> PRDATA == 32'h0)
        else $error("holding register readable");
    a_pins_after_reset: assert property (disable iff (1'b0)
        !RST_N |=> DATA_OE_N && CK_OE_N && CK_O && !DATA_O)
        else $error("pins wrong after reset");
    a_drive_pair: assert property (!DATA_OE_N |-> !CK_OE_N)
        else $error("data driven without clock");
    a_data_on_lead: assert property (
        !DATA_OE_N && !$past(DATA_OE_N) && $changed(DATA_O) |-> $changed(CK_O))
        else $error("data changed without clock edge");

    c_unmapped: cover property (acc && PSLVERR);
    c_sync_clock: cover property (!DATA_OE_N && $rose(CK_O));
    c_long_low: cover property (DATA_OE_N && !CK_O [*8]);
endmodule

bind sbm_serial_port sbm_serial_port_props i_props
(
    .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N), .CK_O(CK_O), .CK_OE_N(CK_OE_N)
);

// File: dv/sbm_link_partner.sv
`timescale 1ns/1ps

module sbm_link_partner
#(
    parameter int BIT = 12
)
(
    input  wire logic CLK,
    input  wire logic sync_mode,
    input  wire logic cpol,
    input  wire logic ck,
    input  wire logic dat,
    output logic      line
);
    logic [15:0] frames[$];
    logic [15:0] sync_word;
    int          sync_n;

    // Bus idles recessive high through its pull-up
    initial
    begin
        line      = 1'b1;
        sync_word = 16'h0000;
        sync_n    = 0;
    end

    // Clocked slave samples on the trailing edge
    always @(ck)
        if (sync_mode && ck === cpol && sync_n < 16)
        begin
            sync_word[sync_n] = dat;
            sync_n++;
        end

    // Line node: count slots up to the first high stop after eight
    initial
    begin
        int          n;
        logic [15:0] d;
        forever
        begin
            @(negedge ck);
            if (!sync_mode)
            begin
                n = 0;
                d = 16'h0000;
                repeat (BIT / 2) @(posedge CLK);
                do
                begin
                    repeat (BIT) @(posedge CLK);
                    if (n < 16)
                        d[n] = ck;
                    n++;
                end
                while (!(ck === 1'b1 && n >= 9));
                frames.push_back({8'(n - 1), d[7:0]});
            end
        end
    end

    // Frame sender, lsb first, one slot per bit
    task automatic send(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++)
        begin
            line <= bits[i];
            repeat (BIT) @(posedge CLK);
        end
        line <= 1'b1;
    endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
`include "sbm_cfg.svh"

module tb;
    logic        CLK;
    logic        RST_N;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        DATA_I;
    logic        DATA_O;
    logic        DATA_OE_N;
    logic        CK_O;
    logic        CK_OE_N;
    logic        line;
    logic        sync_mode;
    logic        cpol;
    logic [31:0] rdat;
    logic        rerr;
    int          failures;
    int          n_checks;
    int          cycles = 0;

    // Data pin level from both parties
    assign DATA_I = DATA_OE_N ? line : DATA_O;

    sbm_serial_port i_sbm_serial_port
    (
        .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N), .CK_O(CK_O), .CK_OE_N(CK_OE_N)
    );

    sbm_link_partner i_sbm_link_partner
    (
        .CLK(CLK), .sync_mode(sync_mode), .cpol(cpol), .ck(CK_O), .dat(DATA_O), .line(line)
    );

    // 250 MHz clock
    initial
    begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Hang guard
    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One bus transfer, held until ready is seen
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge CLK);
        PSEL   <= 1'b1;
        PWRITE <= wr;
        PADDR  <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
            @(posedge CLK);
        while (PREADY !== 1'b1);
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wait_stat(input int b, input logic v);
        do
            apb(1'b0, `SBM_OFS_STATUS, 32'h0);
        while (rdat[b] !== v);
    endtask

    task automatic t_regs();
        apb(1'b0, `SBM_OFS_CTRL, 32'h0);
        chk(rdat, 32'h0, "ctrl reset");
        apb(1'b0, `SBM_OFS_RATE, 32'h0);
        chk(rdat, 32'h67, "rate reset");
        apb(1'b0, `SBM_OFS_STATUS, 32'h0);
        chk({30'h0, rdat[1:0]}, 32'h3, "status idle");
        apb(1'b0, `SBM_OFS_TXDATA, 32'h0);
        chk(rdat, 32'h0, "holding read");
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, rerr}, 32'h1, "unmapped error");
        apb(1'b1, `SBM_OFS_RATE, 32'h0000000B);
        apb(1'b0, `SBM_OFS_RATE, 32'h0);
        chk(rdat, 32'h0000000B, "rate readback");
    endtask

    task automatic t_break_tx();
        apb(1'b1, `SBM_OFS_CTRL, 32'h19);
        apb(1'b1, `SBM_OFS_TXDATA, 32'hA5);
        wait_stat(1, 1'b1);
        apb(1'b1, `SBM_OFS_TXDATA, 32'h55);
        apb(1'b0, `SBM_OFS_STATUS, 32'h0);
        chk({31'h0, rdat[0]}, 32'h0, "shifter busy in break");
        while (i_sbm_link_partner.frames.size() < 2)
            @(posedge CLK);
        chk({16'h0, i_sbm_link_partner.frames[0]}, 32'h0C00, "break frame");
        chk({16'h0, i_sbm_link_partner.frames[1]}, 32'h0855, "sync after break");
        apb(1'b0, `SBM_OFS_CTRL, 32'h0);
        chk(rdat, 32'h9, "break request cleared");
        wait_stat(0, 1'b1);
        chk({30'h0, rdat[1:0]}, 32'h3, "idle after frames");
        apb(1'b1, `SBM_OFS_CTRL, 32'h0);
    endtask

    task automatic t_sync(input logic [31:0] ctl, input logic [7:0] d1, input logic [7:0] d2,
                          input logic two, input int nb, input logic [31:0] exp);
        sync_mode = 1'b1;
        cpol      = ctl[9];
        apb(1'b1, `SBM_OFS_CTRL, ctl);
        repeat (3) @(posedge CLK);
        chk({31'h0, CK_O}, {31'h0, ctl[9]}, "clock idle level");
        chk({30'h0, DATA_OE_N, CK_OE_N}, 32'h0, "drivers on");
        i_sbm_link_partner.sync_n    = 0;
        i_sbm_link_partner.sync_word = 16'h0000;
        apb(1'b1, `SBM_OFS_TXDATA, {24'h0, d1});
        if (two)
        begin
            wait_stat(1, 1'b1);
            apb(1'b1, `SBM_OFS_TXDATA, {24'h0, d2});
        end
        while (i_sbm_link_partner.sync_n < nb)
            @(posedge CLK);
        repeat (40) @(posedge CLK);
        chk(32'(i_sbm_link_partner.sync_n), 32'(nb), "clock count");
        chk({16'h0, i_sbm_link_partner.sync_word}, exp, "shifted bits");
        chk({31'h0, CK_O}, {31'h0, ctl[9]}, "clock back idle");
        apb(1'b1, `SBM_OFS_CTRL, 32'h0);
        sync_mode = 1'b0;
    endtask

    task automatic t_rx_dir();
        sync_mode = 1'b1;
        cpol      = 1'b0;
        apb(1'b1, `SBM_OFS_CTRL, 32'h08F);
        repeat (3) @(posedge CLK);
        i_sbm_link_partner.sync_n = 0;
        apb(1'b1, `SBM_OFS_TXDATA, 32'h33);
        repeat (200) @(posedge CLK);
        chk(32'(i_sbm_link_partner.sync_n), 32'h0, "no transmit when receiving");
        apb(1'b1, `SBM_OFS_CTRL, 32'h0);
        sync_mode = 1'b0;
    endtask

    task automatic t_break_rx();
        apb(1'b1, `SBM_OFS_CTRL, 32'h101);
        i_sbm_link_partner.send(16'h0000, 13);
        wait_stat(2, 1'b1);
        chk({31'h0, rdat[3]}, 32'h1, "framing error");
        apb(1'b0, `SBM_OFS_RXDATA, 32'h0);
        chk(rdat, 32'h0, "break data");
    endtask

    task automatic t_wake();
        apb(1'b1, `SBM_OFS_CTRL, 32'h901);
        fork
            i_sbm_link_partner.send(16'h0000, 13);
            begin
                repeat (20) @(posedge CLK);
                apb(1'b0, `SBM_OFS_STATUS, 32'h0);
                chk({31'h0, rdat[2]}, 32'h1, "wake flag");
                apb(1'b0, `SBM_OFS_CTRL, 32'h0);
                chk(rdat, 32'h901, "wake held low");
                apb(1'b0, `SBM_OFS_RXDATA, 32'h0);
            end
        join
        repeat (10) @(posedge CLK);
        apb(1'b0, `SBM_OFS_CTRL, 32'h0);
        chk(rdat, 32'h101, "wake cleared on rise");
        apb(1'b0, `SBM_OFS_STATUS, 32'h0);
        chk({31'h0, rdat[2]}, 32'h0, "no char during wake");
        i_sbm_link_partner.send(16'h02AA, 10);
        wait_stat(2, 1'b1);
        apb(1'b0, `SBM_OFS_RXDATA, 32'h0);
        chk(rdat, 32'h55, "byte after wake");
    endtask

    // Main sequence
    initial
    begin
        RST_N     = 1'b0;
        PSEL      = 1'b0;
        PENABLE   = 1'b0;
        PWRITE    = 1'b0;
        PADDR     = 8'h00;
        PWDATA    = 32'h0;
        sync_mode = 1'b0;
        cpol      = 1'b0;
        failures  = 0;
        n_checks  = 0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        t_regs();
        t_break_tx();
        t_sync(32'h00F, 8'hA6, 8'h5A, 1'b1, 16, 32'h5AA6);
        t_sync(32'h26F, 8'h3C, 8'h00, 1'b0, 9, 32'h13C);
        t_sync(32'h40F, 8'h81, 8'h00, 1'b0, 8, 32'h7E);
        t_rx_dir();
        t_break_rx();
        t_wake();
        conclude();
    end
endmodule
